// [logic/sipo_map.vh]
// Constants for the serial-in parallel-out output expander
`ifndef SIPO_MAP_VH
`define SIPO_MAP_VH
`define SIPO_WIDTH 12
`define SIPO_MSB 11
`define SIPO_ZERO 12'h000
`define SIPO_LOW1 1'h0
`define SIPO_HIGH1 1'h1
`define SIPO_NPINS 4
`define SIPO_PIN_CLK 3
`define SIPO_PIN_DATA 2
`define SIPO_PIN_STROBE 1
`define SIPO_PIN_CLEAR 0
`endif

// [logic/sipo_sync.v]
// Two-flop synchroniser for one pin input
module sipo_sync (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // Pin side
  input wire i_pin,
  // Clock side
  output wire o_level
);
`include "sipo_map.vh"
  reg meta_q;
  reg sync_q;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= `SIPO_LOW1;
      sync_q <= `SIPO_LOW1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
    end
  end
  assign o_level = sync_q;
endmodule // sipo_sync

// [logic/sipo_expander.v]
// Serial-in parallel-out 12-bit output expander, top level
module sipo_expander (
  // System clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // Host serial pins
  input wire i_ser_clk,
  input wire i_ser_data,
  input wire i_load_strobe,
  input wire i_clear_n,
  // Parallel outputs
  output reg [11:0] o_par_out
);
`include "sipo_map.vh"

  // ****************************************
  // Local codes
  // ****************************************
  // Latch modes, decoded once and shared by every output bit
  // Hold: strobe high, latches keep their value
  localparam [1:0] MODE_HOLD = 2'h0;

  // Live: strobe low and a serial edge, latches take the new word
  localparam [1:0] MODE_LIVE = 2'h1;

  // Load: strobe low with no edge, latches copy the register
  localparam [1:0] MODE_LOAD = 2'h2;

  // Clear: clear pin low, latches forced low
  localparam [1:0] MODE_CLEAR = 2'h3;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins are asynchronous; two flops each keep metastability out
  // Limitation: each pin level must last more than one system clock to be seen
  // Strobe enters inverted so a reset sync reads as the idle high level

  wire clk_s;
  wire data_s;
  wire strobe_s;
  wire clear_n_s;
  wire strobe_n_s;
  // Raw and synced pin levels, indexed by pin
  wire [`SIPO_NPINS-1:0] pins_raw;
  wire [`SIPO_NPINS-1:0] pins_s;

  // Pin indices live in the map header
  // Serial clock
  assign pins_raw[`SIPO_PIN_CLK] = i_ser_clk;
  // Serial data
  assign pins_raw[`SIPO_PIN_DATA] = i_ser_data;
  // Strobe, inverted
  assign pins_raw[`SIPO_PIN_STROBE] = ~i_load_strobe;
  // Clear, active low
  assign pins_raw[`SIPO_PIN_CLEAR] = i_clear_n;

  genvar gi;
  generate
    for (gi = 0; gi < `SIPO_NPINS; gi = gi + 1) begin : g_sync
      sipo_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(pins_raw[gi]),
        .o_level(pins_s[gi])
      );
    end
  endgenerate

  // Synced levels
  assign clk_s = pins_s[`SIPO_PIN_CLK];
  assign data_s = pins_s[`SIPO_PIN_DATA];
  assign strobe_n_s = pins_s[`SIPO_PIN_STROBE];
  // Back to true polarity
  assign strobe_s = ~strobe_n_s;
  assign clear_n_s = pins_s[`SIPO_PIN_CLEAR];

  // ****************************************
  // Serial clock edge detect
  // ****************************************
  // Data and clock share sync delay, so data is sampled as at the pin edge
  // One pulse per rising serial edge, whatever its length
  reg clk_prev_q;
  wire clk_prev_d;
  wire shift_en;

  assign clk_prev_d = clk_s;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_prev_q <= `SIPO_LOW1;
    end else begin
      clk_prev_q <= clk_prev_d;
    end
  end

  assign shift_en = clk_s & ~clk_prev_q;

  // ****************************************
  // Strobe edge detect
  // ****************************************
  // Reset value matches the idle pin level, so no false fall after reset
  reg strobe_prev_q;
  wire strobe_prev_d;
  wire strobe_fall;

  assign strobe_prev_d = strobe_s;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      strobe_prev_q <= `SIPO_HIGH1;
    end else begin
      strobe_prev_q <= strobe_prev_d;
    end
  end

  assign strobe_fall = strobe_prev_q & ~strobe_s;

  // ****************************************
  // Shift register, no reset
  // ****************************************
  // No reset term: powers up undefined, clear never touches it
  // Newest bit at bit zero, oldest falls out of the top
  reg [`SIPO_MSB:0] shift_q;
  wire [`SIPO_MSB:0] shift_d;

  assign shift_d = {shift_q[`SIPO_MSB-1:0], data_s};

  // Only a detected serial edge moves the register
  always @(posedge i_clk_sys) begin
    if (shift_en) begin
      shift_q <= shift_d;
    end
  end

  // ****************************************
  // Latch mode decode
  // ****************************************
  // Clear wins over strobe, whatever the clock does
  // Trade-off: clear acts after the sync delay, not at once
  // Strobe low with no edge keeps the latch transparent
  reg [1:0] mode_d;

  always @* begin
    mode_d = MODE_HOLD;
    if (!clear_n_s) begin
      mode_d = MODE_CLEAR;
    end else if (!strobe_s && shift_en) begin
      mode_d = MODE_LIVE;
    end else if (strobe_fall) begin
      mode_d = MODE_LOAD;
    end else if (!strobe_s) begin
      mode_d = MODE_LOAD;
    end
  end

  // ****************************************
  // Output latch, one slice per bit
  // ****************************************
  // Each bit picks from the same decoded mode
  wire [`SIPO_MSB:0] par_out_d;

  genvar gb;
  generate
    for (gb = 0; gb < `SIPO_WIDTH; gb = gb + 1) begin : g_latch
      reg bit_d;

      always @* begin
        case (mode_d)
          MODE_HOLD: begin
            bit_d = o_par_out[gb];
          end

          MODE_LIVE: begin
            bit_d = shift_d[gb];
          end

          MODE_LOAD: begin
            bit_d = shift_q[gb];
          end

          MODE_CLEAR: begin
            bit_d = `SIPO_LOW1;
          end

          default: begin
            bit_d = o_par_out[gb];
          end
        endcase
      end

      assign par_out_d[gb] = bit_d;
    end
  endgenerate

  // ****************************************
  // Output flops
  // ****************************************
  // Latch feeds the flops only, the pins are driven from the flops
  // System reset only; the clear pin acts through the mode decode
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_par_out <= `SIPO_ZERO;
    end else begin
      o_par_out <= par_out_d;
    end
  end

endmodule // sipo_expander

// [tb/sipo_host.sv]
// Host model driving the expander pins
module sipo_host (
  // Pacing clock
  input wire clk,
  // Pins toward the expander
  output logic sck,
  output logic sd,
  output logic strobe,
  output logic clear_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle, clear held low until the bench lets go
  initial begin
    sck = 1'h0;
    sd = 1'h0;
    strobe = 1'h1;
    clear_n = 1'h0;
  end
  // Data settles a cycle before the clock rises and holds past its fall
  task automatic shift(input logic b);
    @(posedge clk);
    sd <= b;
    @(posedge clk);
    sck <= 1'h1;
    repeat (4) @(posedge clk);
    sck <= 1'h0;
    repeat (2) @(posedge clk);
    sd <= ~b;
    repeat (2) @(posedge clk);
  endtask
  task automatic send(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) shift(w[i]);
  endtask
  task automatic setstb(input logic v);
    @(posedge clk);
    strobe <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic setclr(input logic v);
    @(posedge clk);
    clear_n <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule // sipo_host

// [tb/sipo_assertions.sv]
// Checker for the output expander ports
module sipo_chk (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // Host pins
  input wire i_ser_clk,
  input wire i_ser_data,
  input wire i_load_strobe,
  input wire i_clear_n,
  // Parallel outputs
  input wire [11:0] o_par_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_live; (!i_load_strobe && i_clear_n)[*6]; endsequence
  sequence s_hold; (i_load_strobe && i_clear_n)[*5]; endsequence
  AST_CLR_LOW: assert property ((!i_clear_n)[*4] |-> o_par_out == 12'h000)
    else $error("outputs not low under clear");
  AST_CLR_FELL: assert property ($fell(i_clear_n) |-> ##4 o_par_out == 12'h000)
    else $error("outputs not low after clear fell");
  AST_SHIFT: assert property (s_live ##0 $rose(i_ser_clk) |-> ##5 o_par_out ==
    {$past(o_par_out[10:0], 5), $past(i_ser_data, 5)}) else $error("shift");
  AST_BIT0: assert property (s_live ##0 $rose(i_ser_clk) ##0 i_ser_data |-> ##5 o_par_out[0])
    else $error("bit0");
  AST_FROZEN: assert property (s_hold |-> $stable(o_par_out)) else $error("frozen");
  AST_SHIFT_HOLD: assert property (s_hold ##1 $rose(i_ser_clk) |-> ##5 $stable(o_par_out))
    else $error("hold");
  AST_RISE_CAUSE: assert property ($rose(|o_par_out) |-> $past(i_clear_n, 2))
    else $error("rise without clear high");
  AST_IDLE: assert property (($stable(i_load_strobe) && i_clear_n && !i_ser_clk)[*8]
    |-> $stable(o_par_out)) else $error("idle");
endmodule // sipo_chk
bind sipo_expander sipo_chk u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ser_clk(i_ser_clk),
  .i_ser_data(i_ser_data), .i_load_strobe(i_load_strobe), .i_clear_n(i_clear_n),
  .o_par_out(o_par_out));

// [tb/sipo_expander_tb.sv]
// Testbench for the output expander
`define CHK(n, e, s) begin @(negedge i_clk_sys); checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module sipo_expander_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys;
  logic i_nrst;
  wire sck;
  wire sd;
  wire strobe;
  wire clear_n;
  wire [11:0] o_par_out;
  int checks;
  int n_mismatch;
  initial begin
    i_clk_sys = 1'h0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  sipo_host host (.clk(i_clk_sys), .sck(sck), .sd(sd), .strobe(strobe), .clear_n(clear_n));
  sipo_expander dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ser_clk(sck), .i_ser_data(sd),
    .i_load_strobe(strobe), .i_clear_n(clear_n), .o_par_out(o_par_out));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_load;
    host.send(12'hA5C);
    `CHK("hold", 12'h000, o_par_out)
    host.setstb(1'h0);
    `CHK("load", 12'hA5C, o_par_out)
  endtask
  task automatic t_live;
    host.shift(1'h1);
    `CHK("live", 12'h4B9, o_par_out)
    host.setstb(1'h1);
    `CHK("kept", 12'h4B9, o_par_out)
  endtask
  task automatic t_clear;
    host.setclr(1'h0);
    `CHK("clear", 12'h000, o_par_out)
    host.setclr(1'h1);
    host.setstb(1'h0);
    `CHK("reload", 12'h4B9, o_par_out)
  endtask
  task automatic t_hold;
    host.setstb(1'h1);
    host.shift(1'h0);
    `CHK("frozen", 12'h4B9, o_par_out)
    host.setstb(1'h0);
    `CHK("next", 12'h972, o_par_out)
  endtask
  initial begin
    #20000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    checks = 0;
    n_mismatch = 0;
    i_nrst = 1'h0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    host.setclr(1'h1);
    t_load();
    t_live();
    t_clear();
    t_hold();
    stop_test();
  end
endmodule // sipo_expander_tb
